// File: adr_timing_regs.vh
`ifndef ADR_TIMING_REGS_VH
`define ADR_TIMING_REGS_VH
`define ADR_CLK_HZ 20000000
`define ADR_SELF_REFRESH_US 100
`define ADR_SELF_REFRESH_CYC 16'h07D0
`define ADR_REFRESH_INTERVAL_US 64000
`define ADR_REFRESH_ROWS 1024
`define ADR_REFRESH_GAP_CYC 16'h04E2
`define ADR_T_SETUP 8'h02
`define ADR_T_STROBE 8'h03
`define ADR_T_PRECHARGE 8'h03
`define ADR_OP_READ 3'h0
`define ADR_OP_WRITE 3'h1
`define ADR_OP_RMW 3'h2
`define ADR_OP_ROWREF 3'h3
`define ADR_OP_COLREF 3'h4
`define ADR_OP_SLEEP 3'h5
`endif

// File: adr_delay.v
`timescale 1ns/100ps
module adr_delay #(
	parameter W = 16
) (
	input wire clk,
	input wire srst,
	input wire start,
	input wire [W-1:0] count,
	output wire done
);
	reg [W-1:0] left;
	reg run;
	always @(posedge clk) begin
		if (srst) begin
			left <= {W{1'b0}};
			run <= 1'b0;
		end else if (start) begin
			left <= count;
			run <= 1'b1;
		end else if (run) begin
			if (left <= {{(W-1){1'b0}}, 1'b1}) begin
				run <= 1'b0;
			end
			left <= left - {{(W-1){1'b0}}, 1'b1};
		end
	end
	assign done = run && (left <= {{(W-1){1'b0}}, 1'b1});
endmodule

// File: adr_ctrl.v
`timescale 1ns/100ps
`include "adr_timing_regs.vh"
// Contract
// - row address set before row strobe falls and held after.
// - column address set after row strobe falls, before column strobe falls.
// - write select low around falling column strobe for a write.
// - write data driven before column strobe falls and held after.
// - both strobes return high before a write is finished.
// - page write keeps row strobe low, repeating column steps.
// - read-modify-write starts as read with write select high.
// - output gate low to read, then high; device releases data.
// - new data driven a setup period before write select falls.
// - allow longer cycle, both strobes high before finishing.
// - spread row refreshes over the interval, then restart.
// - row-only refresh: row address, row strobe low, column strobe high.
// - column-first refresh: column strobe low, write select high, then row.
// - end column-first refresh: column strobe high, then row strobe; sleep exit raises both strobes in the same cycle.
// - row strobe low 100 us in column-first refresh enters sleep.
// - hidden refresh within one column strobe low period.
module adr_ctrl #(
	parameter AW = 10,
	parameter DW = 16,
	parameter [7:0] T_SETUP = `ADR_T_SETUP,
	parameter [7:0] T_STROBE = `ADR_T_STROBE,
	parameter [7:0] T_PRECHARGE = `ADR_T_PRECHARGE,
	parameter [15:0] SLEEP_CYC = `ADR_SELF_REFRESH_CYC,
	parameter [15:0] REFRESH_GAP = `ADR_REFRESH_GAP_CYC
) (
	input wire clk,
	input wire srst,
	input wire reqValid,
	output wire reqReady,
	input wire [2:0] reqOp,
	input wire [AW-1:0] reqRow,
	input wire [AW-1:0] reqCol,
	input wire [DW-1:0] reqData,
	input wire reqPageNext,
	input wire [AW-1:0] reqNextCol,
	input wire [DW-1:0] reqNextData,
	input wire autoRefreshEn,
	input wire sleepExit,
	output reg rspValid,
	output reg [DW-1:0] rspData,
	output reg sleeping,
	output reg rowStrobeN,
	output reg colStrobeN,
	output reg writeSelN,
	output reg outGateN,
	output reg [AW-1:0] memAddr,
	output reg [DW-1:0] dqOut,
	output reg dqOe,
	input wire [DW-1:0] dqIn
);
	localparam S_IDLE = 4'h0;
	localparam S_ROWSET = 4'h1;
	localparam S_ROWLOW = 4'h2;
	localparam S_COLLOW = 4'h3;
	localparam S_COLHIGH = 4'h4;
	localparam S_RMWRD = 4'h5;
	localparam S_RMWDAT = 4'h6;
	localparam S_RMWWE = 4'h7;
	localparam S_END = 4'h8;
	localparam S_PRE = 4'h9;
	localparam S_CFCAS = 4'hA;
	localparam S_CFRAS = 4'hB;
	localparam S_CFCASUP = 4'hC;
	localparam S_SLEEP = 4'hD;
	reg [3:0] state;
	reg [2:0] op;
	reg [AW-1:0] col;
	reg [DW-1:0] wdata;
	reg [AW-1:0] refRow;
	reg [15:0] gapCnt;
	reg refDue;
	reg dStart;
	reg [15:0] dCount;
	wire dDone;
	reg [DW-1:0] dqS1, dqS2, dqS3;
	adr_delay #(.W(16)) u_delay (
		.clk(clk),
		.srst(srst),
		.start(dStart),
		.count(dCount),
		.done(dDone)
	);
	function [15:0] cyc;
		input [7:0] n;
		begin
			cyc = (n == 8'h00) ? 16'h0001 : {8'h00, n};
		end
	endfunction
	// data returns from a pin, so three stages; a plain read counts a word once stages two and three agree, read-modify-write takes stage three as is
	always @(posedge clk) begin
		dqS1 <= dqIn;
		dqS2 <= dqS1;
		dqS3 <= dqS2;
	end
	// refresh pacing: one row per gap, the row index wraps to restart the sweep
	always @(posedge clk) begin
		if (srst) begin
			gapCnt <= 16'h0000;
			refDue <= 1'b0;
		end else begin
			if (gapCnt >= REFRESH_GAP - 16'h0001) begin
				gapCnt <= 16'h0000;
			end else begin
				gapCnt <= gapCnt + 16'h0001;
			end
			if (autoRefreshEn && gapCnt == 16'h0000) begin
				refDue <= 1'b1;
			end else if (state == S_PRE && op >= `ADR_OP_ROWREF && dDone) begin
				refDue <= 1'b0;
			end
		end
	end
	assign reqReady = (state == S_IDLE) && !refDue;
	always @(posedge clk) begin
		if (srst) begin
			state <= S_IDLE;
			op <= `ADR_OP_READ;
			col <= {AW{1'b0}};
			wdata <= {DW{1'b0}};
			refRow <= {AW{1'b0}};
			rowStrobeN <= 1'b1;
			colStrobeN <= 1'b1;
			writeSelN <= 1'b1;
			outGateN <= 1'b1;
			memAddr <= {AW{1'b0}};
			dqOut <= {DW{1'b0}};
			dqOe <= 1'b0;
			rspValid <= 1'b0;
			rspData <= {DW{1'b0}};
			sleeping <= 1'b0;
			dStart <= 1'b0;
			dCount <= 16'h0001;
		end else begin
			dStart <= 1'b0;
			rspValid <= 1'b0;
			case (state)
			S_IDLE: begin
				if (refDue) begin
					op <= `ADR_OP_ROWREF;
					memAddr <= refRow;
					state <= S_ROWSET;
					dStart <= 1'b1;
					dCount <= cyc(T_SETUP);
				end else if (reqValid) begin
					op <= reqOp;
					col <= reqCol;
					wdata <= reqData;
					if (reqOp == `ADR_OP_COLREF || reqOp == `ADR_OP_SLEEP) begin
						writeSelN <= 1'b1;
						state <= S_CFCAS;
						colStrobeN <= 1'b0;
						dStart <= 1'b1;
						dCount <= cyc(T_SETUP);
					end else begin
						memAddr <= reqRow;
						state <= S_ROWSET;
						dStart <= 1'b1;
						dCount <= cyc(T_SETUP);
					end
				end
			end
			S_ROWSET: begin
				if (dDone) begin
					rowStrobeN <= 1'b0;
					state <= S_ROWLOW;
					dStart <= 1'b1;
					dCount <= (op == `ADR_OP_ROWREF) ? cyc(T_STROBE) : cyc(T_SETUP);
				end
			end
			S_ROWLOW: begin
				if (dDone) begin
					if (op == `ADR_OP_ROWREF) begin
						rowStrobeN <= 1'b1;
						refRow <= refRow + {{(AW-1){1'b0}}, 1'b1};
						state <= S_PRE;
						dStart <= 1'b1;
						dCount <= cyc(T_PRECHARGE);
					end else begin
						memAddr <= col;
						writeSelN <= !(op == `ADR_OP_WRITE);
						if (op == `ADR_OP_WRITE) begin
							dqOut <= wdata;
							dqOe <= 1'b1;
						end
						outGateN <= !(op == `ADR_OP_READ);
						state <= S_COLLOW;
						dStart <= 1'b1;
						dCount <= cyc(T_SETUP);
					end
				end
			end
			S_COLLOW: begin
				if (dDone && colStrobeN) begin
					colStrobeN <= 1'b0;
					dStart <= 1'b1;
					dCount <= cyc(T_STROBE);
				end else if (dDone) begin
					if (op == `ADR_OP_RMW) begin
						outGateN <= 1'b0;
						state <= S_RMWRD;
						dStart <= 1'b1;
						dCount <= cyc(T_STROBE) + 16'h0002;
					end else begin
						if (op == `ADR_OP_READ && dqS2 == dqS3) begin
							rspData <= dqS3;
							rspValid <= 1'b1;
						end
						writeSelN <= 1'b1;
						state <= refDue ? S_CFCAS : S_COLHIGH;
						dStart <= 1'b1;
						dCount <= cyc(T_PRECHARGE);
						if (refDue) begin
							{rowStrobeN, outGateN, dqOe} <= 3'h6;
							op <= `ADR_OP_COLREF;
						end else begin
							colStrobeN <= 1'b1;
						end
					end
				end
			end
			S_COLHIGH: begin
				dqOe <= 1'b0;
				if (dDone) begin
					if (reqPageNext && !refDue) begin
						col <= reqNextCol;
						wdata <= reqNextData;
						state <= S_ROWLOW;
						dStart <= 1'b1;
						dCount <= 16'h0001;
					end else begin
						state <= S_END;
					end
				end
			end
			S_RMWRD: begin
				if (dDone) begin
					rspData <= dqS3;
					rspValid <= 1'b1;
					outGateN <= 1'b1;
					state <= S_RMWDAT;
					dStart <= 1'b1;
					dCount <= cyc(T_SETUP);
				end
			end
			S_RMWDAT: begin
				if (dDone) begin
					dqOut <= wdata;
					dqOe <= 1'b1;
					state <= S_RMWWE;
					dStart <= 1'b1;
					dCount <= cyc(T_SETUP);
				end
			end
			S_RMWWE: begin
				if (dDone && writeSelN) begin
					writeSelN <= 1'b0;
					dStart <= 1'b1;
					dCount <= cyc(T_STROBE);
				end else if (dDone) begin
					writeSelN <= 1'b1;
					colStrobeN <= 1'b1;
					state <= S_END;
				end
			end
			S_END: begin
				colStrobeN <= 1'b1;
				rowStrobeN <= 1'b1;
				outGateN <= 1'b1;
				dqOe <= 1'b0;
				state <= S_PRE;
				dStart <= 1'b1;
				dCount <= cyc(T_PRECHARGE);
			end
			S_PRE: begin
				if (dDone) begin
					state <= S_IDLE;
				end
			end
			S_CFCAS: begin
				if (dDone) begin
					rowStrobeN <= 1'b0;
					state <= S_CFRAS;
					dStart <= 1'b1;
					dCount <= (op == `ADR_OP_SLEEP) ? SLEEP_CYC : cyc(T_STROBE);
				end
			end
			S_CFRAS: begin
				if (dDone) begin
					if (op == `ADR_OP_SLEEP) begin
						sleeping <= 1'b1;
						state <= S_SLEEP;
					end else begin
						colStrobeN <= 1'b1;
						state <= S_CFCASUP;
						dStart <= 1'b1;
						dCount <= cyc(T_SETUP);
					end
				end
			end
			S_CFCASUP: begin
				if (dDone) begin
					rowStrobeN <= 1'b1;
					state <= S_PRE;
					dStart <= 1'b1;
					dCount <= cyc(T_PRECHARGE);
				end
			end
			S_SLEEP: begin
				// strobes stay low; the device paces itself until asked to leave
				if (sleepExit) begin
					rowStrobeN <= 1'b1;
					colStrobeN <= 1'b1;
					sleeping <= 1'b0;
					state <= S_PRE;
					dStart <= 1'b1;
					dCount <= cyc(T_PRECHARGE);
				end
			end
			default: begin
				state <= S_IDLE;
			end
			endcase
		end
	end
endmodule

// File: adr_ctrl_props.sv
`timescale 1ns/100ps
module adr_ctrl_props #(
	parameter AW = 10,
	parameter [15:0] SLEEP_CYC = 16'h07D0
) (
	input wire clk,
	input wire srst,
	input wire reqReady,
	input wire sleeping,
	input wire rowStrobeN,
	input wire colStrobeN,
	input wire writeSelN,
	input wire outGateN,
	input wire dqOe,
	input wire [AW-1:0] memAddr
);
	// cycles with both strobes low, to judge sleep entry
	reg [15:0] lowCnt;
	always @(posedge clk) begin
		if (srst | rowStrobeN | colStrobeN)
			lowCnt <= 16'h0000;
		else
			lowCnt <= lowCnt + 16'h0001;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence colFirst;
		$fell(colStrobeN) && rowStrobeN;
	endsequence
	sequence rowJoins;
		writeSelN ##[1:40] ($fell(rowStrobeN) && !colStrobeN);
	endsequence
	sequence colWrite;
		$fell(colStrobeN) && !writeSelN;
	endsequence
	// a refresh under a held column strobe: the row strobe drops again soon
	sequence hiddenRef;
		##[1:20] ($fell(rowStrobeN) && !colStrobeN);
	endsequence
	a_row_follows_col: assert property (colFirst |-> rowJoins)
		else $error("row strobe late");
	a_row_addr_stable: assert property ($fell(rowStrobeN) && colStrobeN |-> $stable(memAddr) ##1 $stable(memAddr))
		else $error("row address moved");
	a_col_after_row: assert property ($fell(colStrobeN) && !rowStrobeN |-> !$past(rowStrobeN))
		else $error("column strobe early");
	a_write_data_setup: assert property (colWrite |-> dqOe && $past(dqOe))
		else $error("write data late");
	a_wsel_hold: assert property (colWrite |=> !writeSelN && !colStrobeN)
		else $error("write select short");
	a_done_strobes_high: assert property ($rose(reqReady) |-> rowStrobeN && colStrobeN)
		else $error("strobe low at finish");
	a_hidden_refresh: assert property ($rose(rowStrobeN) && !colStrobeN |-> hiddenRef)
		else $error("hidden refresh incomplete");
	a_rmw_data_first: assert property ($fell(writeSelN) && !colStrobeN |-> $past(dqOe))
		else $error("late data");
	a_gate_no_clash: assert property (!outGateN |-> !dqOe)
		else $error("bus clash");
	a_sleep_after_hold: assert property ($rose(sleeping) |-> lowCnt >= SLEEP_CYC - 16'd2)
		else $error("sleep too soon");
	a_busy_while_low: assert property (!rowStrobeN |-> !reqReady)
		else $error("ready mid cycle");
endmodule

// File: adr_dram_model.sv
`timescale 1ns/100ps
module adr_dram_model #(
	parameter AW = 10,
	parameter DW = 16,
	parameter SLEEP_NS = 900
) (
	input wire rowStrobeN,
	input wire colStrobeN,
	input wire writeSelN,
	input wire outGateN,
	input wire [AW-1:0] memAddr,
	input wire [DW-1:0] dqOut,
	input wire dqOe,
	output wire [DW-1:0] dqIn
);
	// only 16x16 cells kept; enough for the bench
	reg [DW-1:0] mem [0:255];
	reg [DW-1:0] rdData = 0, held = 0;
	reg [3:0] row = 0, col = 0;
	reg rdOn = 0, asleep = 0, colSeen = 0, column_first_refresh = 0;
	integer refCnt = 0, rowRefs = 0, lastRefRow = -1;
	realtime tLow = 0;
	wire drv = dqOe | rdOn;
	wire [DW-1:0] bus = dqOe ? dqOut : rdData;
	always @(bus or drv)
		if (drv)
			held = bus;
	assign dqIn = drv ? bus : ~held;
	always @(negedge rowStrobeN) begin
		colSeen = 0;
		column_first_refresh = !colStrobeN;
		tLow = $realtime;
		if (column_first_refresh)
			refCnt = refCnt + 1;
		else
			row = memAddr[3:0];
	end
	always @(posedge rowStrobeN) begin
		if (!colSeen && !column_first_refresh) begin
			rowRefs = rowRefs + 1;
			lastRefRow = row;
		end
		asleep = 0;
	end
	always @(negedge colStrobeN)
		if (!rowStrobeN) begin
			col = memAddr[3:0];
			colSeen = 1;
			if (!writeSelN)
				mem[{row, col}] = dqIn;
			else
				rdData = mem[{row, col}];
		end
	always @(negedge writeSelN)
		if (!rowStrobeN && !colStrobeN)
			mem[{row, col}] = dqIn;
	always @(colStrobeN or outGateN or rowStrobeN or writeSelN or colSeen)
		if (rowStrobeN || outGateN || !writeSelN)
			rdOn = 0;
		else if (!colStrobeN && colSeen)
			rdOn = 1;
	// coarse oscillator; sleep granularity is 100 ns
	initial forever #100 begin
		if (column_first_refresh && !rowStrobeN && !colStrobeN && $realtime - tLow >= SLEEP_NS)
			asleep = 1;
		if (asleep)
			refCnt = refCnt + 1;
	end
endmodule

// File: adr_ctrl_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("wrong value at %0t: %h vs %h", $time, a, b); end end
module adr_ctrl_tb;
	reg clk = 0, srst = 1, reqValid = 0, reqPageNext = 0, autoRefreshEn = 0, sleepExit = 0;
	reg [2:0] reqOp = 0;
	reg [9:0] reqRow = 0, reqCol = 0, reqNextCol = 0;
	reg [15:0] reqData = 0, reqNextData = 0, got = 0;
	wire reqReady, rspValid, sleeping, rowStrobeN, colStrobeN, writeSelN, outGateN, dqOe;
	wire [15:0] rspData, dqOut, dqIn;
	wire [9:0] memAddr;
	integer n_errors = 0, n_checks = 0, r0;
	adr_ctrl #(.SLEEP_CYC(16'd20), .REFRESH_GAP(16'd50)) dut_u (
		.clk(clk), .srst(srst), .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp),
		.reqRow(reqRow), .reqCol(reqCol), .reqData(reqData), .reqPageNext(reqPageNext),
		.reqNextCol(reqNextCol), .reqNextData(reqNextData), .autoRefreshEn(autoRefreshEn),
		.sleepExit(sleepExit), .rspValid(rspValid), .rspData(rspData), .sleeping(sleeping),
		.rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .writeSelN(writeSelN),
		.outGateN(outGateN), .memAddr(memAddr), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn)
	);
	adr_dram_model #(.SLEEP_NS(900)) mdl_u (
		.rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .writeSelN(writeSelN),
		.outGateN(outGateN), .memAddr(memAddr), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn)
	);
	initial begin
		forever #25 clk = ~clk;
	end
	task issue(input [2:0] op, input [9:0] r, input [9:0] c, input [15:0] d);
		integer k;
		begin
			got = 16'h0000;
			@(posedge clk);
			reqOp <= op;
			reqRow <= r;
			reqCol <= c;
			reqData <= d;
			reqValid <= 1'b1;
			@(negedge clk);
			for (k = 0; !reqReady && k < 300; k++)
				@(negedge clk);
			@(posedge clk) reqValid <= 1'b0;
			for (k = 0; k < 300; k++) begin
				@(negedge clk);
				if (rspValid)
					got = rspData;
				if (reqReady)
					break;
			end
		end
	endtask
	task t_access;
		begin
			issue(3'h1, 10'h005, 10'h009, 16'hA5C3);
			`CHK(mdl_u.mem[8'h59], 16'hA5C3)
			issue(3'h0, 10'h005, 10'h009, 16'h0000);
			`CHK(got, 16'hA5C3)
			@(posedge clk) reqPageNext <= 1'b1;
			reqNextCol <= 10'h00A;
			reqNextData <= 16'h1234;
			fork
				issue(3'h1, 10'h005, 10'h003, 16'h0F0F);
				begin
					repeat (2) @(negedge colStrobeN);
					@(posedge clk) reqPageNext <= 1'b0;
				end
			join
			`CHK(mdl_u.mem[8'h53], 16'h0F0F)
			`CHK(mdl_u.mem[8'h5A], 16'h1234)
			issue(3'h2, 10'h005, 10'h009, 16'h7E81);
			`CHK(got, 16'hA5C3)
			`CHK(mdl_u.mem[8'h59], 16'h7E81)
		end
	endtask
	task t_refresh;
		begin
			r0 = mdl_u.refCnt;
			issue(3'h3, 10'h007, 10'h000, 16'h0000);
			`CHK(mdl_u.lastRefRow, 7)
			issue(3'h4, 10'h000, 10'h000, 16'h0000);
			issue(3'h4, 10'h000, 10'h000, 16'h0000);
			`CHK(mdl_u.refCnt - r0, 2)
			r0 = mdl_u.refCnt;
			fork
				issue(3'h5, 10'h000, 10'h000, 16'h0000);
				begin
					wait (sleeping === 1'b1);
					repeat (40) @(posedge clk);
					`CHK(mdl_u.asleep, 1'b1)
					`CHK(mdl_u.refCnt - r0 > 5, 1'b1)
					sleepExit <= 1'b1;
				end
			join
			@(posedge clk) sleepExit <= 1'b0;
			`CHK({sleeping, rowStrobeN, colStrobeN, mdl_u.asleep}, 4'b0110)
		end
	endtask
	task t_hidden;
		begin
			r0 = mdl_u.refCnt;
			// time the request so that a refresh falls due while the access is under way
			do @(posedge clk); while (dut_u.gapCnt != 16'd45);
			autoRefreshEn <= 1'b1;
			issue(3'h0, 10'h005, 10'h009, 16'h0000);
			@(posedge clk) autoRefreshEn <= 1'b0;
			`CHK(got, 16'h7E81)
			`CHK(mdl_u.refCnt - r0, 1)
		end
	endtask
	task t_auto;
		begin
			r0 = mdl_u.rowRefs;
			@(posedge clk) autoRefreshEn <= 1'b1;
			repeat (260) @(posedge clk);
			autoRefreshEn <= 1'b0;
			`CHK(mdl_u.rowRefs - r0 >= 4, 1'b1)
			// access still served once refresh has been running
			issue(3'h0, 10'h005, 10'h009, 16'h0000);
			`CHK(got, 16'h7E81)
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d errors %0d", n_checks, n_errors);
			if (n_errors == 0 && n_checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		t_access;
		t_refresh;
		t_hidden;
		t_auto;
		wrap_up;
	end
	// whole run is well under 1000 cycles; the limit allows 20000
	initial begin
		#1000000;
		n_errors++;
		wrap_up;
	end
endmodule
bind adr_ctrl adr_ctrl_props #(.AW(AW), .SLEEP_CYC(SLEEP_CYC)) chk_u (
	.clk(clk), .srst(srst), .reqReady(reqReady), .sleeping(sleeping),
	.rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .writeSelN(writeSelN),
	.outGateN(outGateN), .dqOe(dqOe), .memAddr(memAddr)
);
